// ==== rtl/bise_edge.sv ====
// Purpose: two-flop synchroniser and rising-edge pulse for one source level
// Assumes: source is asynchronous to i_clk_sys
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module bise_edge import bise_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_level,
  output logic o_rise
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= i_level;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign o_rise = sync_r & ~prev_r;
endmodule

// ==== rtl/bise_pkg.sv ====
// Purpose: shared constants and types for the board interrupt status/enable block
// Assumes: byte-wide register port on the peripheral controller's I/O decode
// Notes: offsets are byte offsets within the controller I/O space
package bise_pkg;
  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [4:0] BISE_OFS_TIMER = 5'h08;
  localparam logic [4:0] BISE_OFS_COMPARE = 5'h0c;
  localparam logic [4:0] BISE_OFS_REQUEST = 5'h18;
  localparam logic [4:0] BISE_OFS_ENABLE = 5'h1c;
  // ****************************************************
  // field positions and reset values
  // ****************************************************
  localparam int BISE_BIT_TIMER = 0;
  localparam int BISE_BIT_FPGA1 = 1;
  localparam int BISE_BIT_FPGA2 = 2;
  localparam int BISE_BIT_RSVD = 3;
  localparam int BISE_BIT_RX = 4;
  localparam int BISE_BIT_TX = 5;
  localparam int BISE_BIT_PB2 = 6;
  localparam int BISE_BIT_PB1 = 7;
  localparam logic [7:0] BISE_RST_REQUEST = 8'h00;
  localparam logic [7:0] BISE_RST_ENABLE = 8'h00;
  localparam logic [7:0] BISE_RST_COMPARE = 8'h00;
  localparam logic [7:0] BISE_RSVD_MASK = 8'h08;

  // raw source levels, all active high
  typedef struct packed {
    logic first_pushbutton;
    logic second_pushbutton;
    logic tx_ready;
    logic rx_ready;
    logic fpga2_irq;
    logic fpga1_irq;
  } bise_src_type;

  // one register port access
  typedef struct packed {
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } bise_wr_type;
endpackage

// ==== rtl/bise_top.sv ====
// Purpose: board interrupt request/enable registers driving the processor IRQ
// Assumes: register port already decoded and synchronous to i_clk_sys
// Notes: sources are edge-captured so a serviced request stays cleared
// What this block does
// - eight-bit request register at offset 0x18
// - bits 7 and 6 are the pushbuttons
// - bit 5 tx ready, bit 4 rx ready
// - bits 2,1,0 fpga2, fpga1, timer; 3 reserved
// - writes set ones and clear zeros
// - enable register at 0x1c reads back writes
// - enable bits align with request bits
// - any enabled request asserts processor interrupt
// - disabled request never asserts the interrupt
// - first fpga rising edge sets bit 1
// - timer equal to compare raises bit 0
// - rx byte available, tx can accept byte
`timescale 1ns/1ps
module bise_top import bise_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire bise_wr_type i_bus,
  input wire logic [4:0] i_rd_addr,
  input wire logic [7:0] i_timer_value,
  input wire bise_src_type i_src,
  output logic [7:0] o_rdata,
  output logic [7:0] o_compare,
  output logic o_irq
);
  // ****************************************************
  // source capture
  // ****************************************************
  logic [5:0] src_rise;
  logic [7:0] set_evt;
  logic [7:0] request_r;
  logic [7:0] enable_r;
  logic [7:0] compare_r;
  logic [7:0] request_nxt;
  logic [7:0] enable_nxt;
  logic wr_cmp;
  logic timer_hit_r;
  logic timer_eq_prev_r;
  logic wr_req;
  logic wr_en;

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_src
      bise_edge u_edge (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_level(i_src[g]),
        .o_rise(src_rise[g])
      );
    end
  endgenerate

  // timer is same-domain logic; one pulse per match, timer left running
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      timer_eq_prev_r <= 1'b0;
      timer_hit_r <= 1'b0;
    end else begin
      timer_eq_prev_r <= (i_timer_value == compare_r);
      timer_hit_r <= (i_timer_value == compare_r) & ~timer_eq_prev_r;
    end
  end

  always_comb begin
    set_evt = 8'h00;
    set_evt[BISE_BIT_TIMER] = timer_hit_r;
    set_evt[BISE_BIT_FPGA1] = src_rise[0];
    set_evt[BISE_BIT_FPGA2] = src_rise[1];
    set_evt[BISE_BIT_RX] = src_rise[2];
    set_evt[BISE_BIT_TX] = src_rise[3];
    set_evt[BISE_BIT_PB2] = src_rise[4];
    set_evt[BISE_BIT_PB1] = src_rise[5];
  end

  // ****************************************************
  // registers
  // ****************************************************
  assign wr_req = i_bus.wr && (i_bus.addr == BISE_OFS_REQUEST);
  assign wr_en = i_bus.wr && (i_bus.addr == BISE_OFS_ENABLE);
  assign wr_cmp = i_bus.wr && (i_bus.addr == BISE_OFS_COMPARE);

  // hardware set wins over a software clear in the same cycle
  always_comb begin
    request_nxt = request_r;
    if (wr_req) begin
      request_nxt = i_bus.wdata;
    end
    request_nxt = (request_nxt | set_evt) & ~BISE_RSVD_MASK;
  end

  // irq is built from next values so it never lags a register write
  always_comb begin
    enable_nxt = enable_r;
    if (wr_en) begin
      enable_nxt = i_bus.wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      request_r <= BISE_RST_REQUEST;
    end else begin
      request_r <= request_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      enable_r <= BISE_RST_ENABLE;
    end else begin
      enable_r <= enable_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      compare_r <= BISE_RST_COMPARE;
    end else if (wr_cmp) begin
      compare_r <= i_bus.wdata;
    end
  end

  // ****************************************************
  // read port
  // ****************************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      unique case (i_rd_addr)
        BISE_OFS_REQUEST: o_rdata <= request_r;
        BISE_OFS_ENABLE: o_rdata <= enable_r;
        BISE_OFS_COMPARE: o_rdata <= compare_r;
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************************
  // interrupt output
  // ****************************************************
  // registered so the IRQ pin never glitches
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(request_nxt & enable_nxt);
    end
  end

  assign o_compare = compare_r;

  // ****************************************************
  // checks
  // ****************************************************
  irq_follows_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    |(request_r & enable_r) |-> o_irq)
    else $error("irq not raised for enabled request");
  irq_masked_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_irq |-> |(request_r & enable_r))
    else $error("irq raised without enabled request");
  req_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_req && set_evt == 8'h00 |=> request_r == ($past(i_bus.wdata) & ~BISE_RSVD_MASK))
    else $error("request write not stored");
  en_readback_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_en ##1 (i_rd_addr == BISE_OFS_ENABLE && !wr_en) |=> o_rdata == $past(i_bus.wdata, 2))
    else $error("enable readback mismatch");
  set_wins_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    src_rise[0] |=> request_r[BISE_BIT_FPGA1])
    else $error("fpga request lost");
  timer_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    timer_hit_r |=> request_r[BISE_BIT_TIMER])
    else $error("timer request lost");
  rsvd_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    request_r[BISE_BIT_RSVD] == 1'b0)
    else $error("reserved bit set");
  reset_clear_a: assert property (@(posedge i_clk_sys)
    !i_rst_n |=> request_r == 8'h00 && enable_r == 8'h00 && !o_irq)
    else $error("reset did not clear");
  pb_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(i_src.first_pushbutton) |-> ##3 request_r[BISE_BIT_PB1])
    else $error("pushbutton request lost");
  // bits hold between writes and events
  req_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !wr_req && set_evt == 8'h00 |=> $stable(request_r))
    else $error("request changed without cause");
  en_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !wr_en |=> $stable(enable_r))
    else $error("enable changed without write");
  rd_request_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_rd_addr == BISE_OFS_REQUEST |=> o_rdata == $past(request_r))
    else $error("request readback mismatch");
  cmp_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_cmp |=> compare_r == $past(i_bus.wdata))
    else $error("compare write not stored");
  fpga2_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    src_rise[1] |=> request_r[BISE_BIT_FPGA2])
    else $error("second fpga request lost");
  rx_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    src_rise[2] |=> request_r[BISE_BIT_RX])
    else $error("receiver request lost");
  tx_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    src_rise[3] |=> request_r[BISE_BIT_TX])
    else $error("transmitter request lost");
  pb2_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    src_rise[4] |=> request_r[BISE_BIT_PB2])
    else $error("second pushbutton request lost");
  timer_once_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    timer_hit_r |=> !timer_hit_r)
    else $error("timer hit longer than one cycle");
  irq_low_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    enable_r == 8'h00 |-> !o_irq)
    else $error("irq raised with all sources disabled");

  irq_seen_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) $rose(o_irq));
  ack_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) $fell(o_irq));
  timer_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) timer_hit_r);
  masked_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (request_r != 8'h00) && !o_irq);
endmodule

// ==== test/bise_host.sv ====
// Purpose: host processor model for byte register traffic
// Assumes: one write strobe per access, reads answer one edge later
// Notes: released write data is inverted so stale bytes never pass
`timescale 1ns/1ps
module bise_host import bise_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rdata,
  output bise_wr_type o_bus,
  output logic [4:0] o_rd_addr
);
  initial begin
    o_bus = '0;
    o_rd_addr = 5'h00;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_bus <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge i_clk_sys);
    o_bus <= '{wr: 1'b0, addr: a, wdata: ~d};
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_rd_addr <= a;
    @(posedge i_clk_sys);
    #1 d = i_rdata;
  endtask
  // handler acknowledge: zero only the serviced bit
  task automatic ack(input logic [7:0] cur, input logic [7:0] m);
    wr(BISE_OFS_REQUEST, cur & ~m);
  endtask
endmodule

// ==== test/tb.sv ====
// Purpose: self-checking bench for the interrupt request/enable block
// Assumes: host model owns the register port
// Notes: sources are held long enough to pass the synchronisers
`timescale 1ns/1ps
`define CHK(nm, ex, ac) chk(nm, ex, ac)
module tb import bise_pkg::*;;
  logic i_clk_sys, i_rst_n, irq;
  bise_wr_type bus;
  bise_src_type src;
  logic [4:0] rd_addr;
  logic [7:0] timer, rdata, cmp;
  int failures = 0;
  int n_compared = 0;
  bise_top uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_bus(bus),
    .i_rd_addr(rd_addr), .i_timer_value(timer), .i_src(src),
    .o_rdata(rdata), .o_compare(cmp), .o_irq(irq));
  bise_host host (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .o_bus(bus),
    .o_rd_addr(rd_addr));
  // ******
  // helpers
  // ******
  task automatic chk(string nm, logic [7:0] ex, logic [7:0] ac);
    n_compared++;
    if (ac !== ex) begin
      failures++;
      $display("unexpected %s exp %h got %h", nm, ex, ac);
    end
  endtask
  task automatic end_sim;
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic t_regs;
    logic [7:0] d;
    host.rd(BISE_OFS_REQUEST, d);
    `CHK("req rst", 8'h00, d);
    host.rd(BISE_OFS_ENABLE, d);
    `CHK("en rst", 8'h00, d);
    host.wr(BISE_OFS_ENABLE, 8'h5a);
    host.rd(BISE_OFS_ENABLE, d);
    `CHK("en rb", 8'h5a, d);
    host.wr(BISE_OFS_REQUEST, 8'hff);
    host.rd(BISE_OFS_REQUEST, d);
    `CHK("req set", 8'hf7, d);
    `CHK("irq on", 8'h01, {7'h00, irq});
    host.wr(BISE_OFS_ENABLE, 8'h08);
    host.rd(BISE_OFS_REQUEST, d);
    `CHK("req kept", 8'hf7, d);
    `CHK("irq off", 8'h00, {7'h00, irq});
    host.wr(BISE_OFS_REQUEST, 8'h00);
    host.rd(5'h04, d);
    `CHK("unmapped", 8'h00, d);
  endtask
  task automatic t_src;
    logic [7:0] d;
    logic [7:0] m[6] = '{8'h02, 8'h04, 8'h10, 8'h20, 8'h40, 8'h80};
    for (int k = 0; k < 6; k++) begin
      host.wr(BISE_OFS_ENABLE, 8'h00);
      @(posedge i_clk_sys) src <= bise_src_type'(6'h01 << k);
      repeat (4) @(posedge i_clk_sys);
      host.rd(BISE_OFS_REQUEST, d);
      `CHK("src req", m[k], d);
      `CHK("src masked", 8'h00, {7'h00, irq});
      host.wr(BISE_OFS_ENABLE, m[k]);
      host.rd(BISE_OFS_REQUEST, d);
      `CHK("src irq", 8'h01, {7'h00, irq});
      host.ack(d, m[k]);
      host.rd(BISE_OFS_REQUEST, d);
      `CHK("held level", 8'h00, d);
      `CHK("irq acked", 8'h00, {7'h00, irq});
      @(posedge i_clk_sys) src <= '0;
    end
  endtask
  task automatic t_timer;
    logic [7:0] d;
    host.wr(BISE_OFS_COMPARE, 8'h05);
    host.rd(BISE_OFS_COMPARE, d);
    `CHK("compare", 8'h05, cmp);
    `CHK("compare rd", 8'h05, d);
    @(posedge i_clk_sys) timer <= 8'h05;
    repeat (4) @(posedge i_clk_sys);
    host.rd(BISE_OFS_REQUEST, d);
    `CHK("timer hit", 8'h01, d);
    host.ack(d, 8'h01);
    repeat (3) @(posedge i_clk_sys);
    host.rd(BISE_OFS_REQUEST, d);
    `CHK("one hit", 8'h00, d);
    @(posedge i_clk_sys) timer <= 8'h06;
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    failures++;
    end_sim();
  end
  initial begin
    i_rst_n = 1'b0;
    src = '0;
    timer = 8'hff;
    repeat (6) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_regs();
    t_src();
    t_timer();
    end_sim();
  end
endmodule
